/* File: inc/lat_map.svh */
`ifndef LAT_MAP_SVH
`define LAT_MAP_SVH
`define WIDE_MASK     32'hFFFF_FFFF
`define NARROW_MASK   32'h00FF_FFFF
`define REAL_OFS_MAX  32'h0000_FFFF
`define REAL_CARRY    20
`define ENT_BASE      31:12
`define ENT_OFS       11:0
`define ENT_D         6
`define ENT_A         5
`define ENT_PCD       4
`define ENT_US        2
`define ENT_RW        1
`define ENT_P         0
`define ENT_BIT       32'h0000_0001
`define DIR_IDX       31:22
`define TBL_IDX       21:12
`define TLB_SET       14:12
`define TLB_TAG       31:15
`define TLB_WAYS      4
`define TLB_SETS      8
`define SEG_COUNT     6
`define SUPER_MAX_CPL 2'h2
`define DESC_HI       32'h0000_0004
`define SEL_TABLE     2
`define SEL_IDX       15:3
`define DLO_BASE      31:16
`define DLO_LIM       15:0
`define DHI_BASE_TOP  31:24
`define DHI_BASE_MID  7:0
`define DHI_LIM       19:16
`define DHI_ATTR      15:8
`endif

/* File: inc/lat_pkg.sv */
package lat_pkg;
  typedef logic [31:0] word_t;
  typedef struct packed {
    logic [16:0] tag;
    logic [19:0] frame;
    logic        us;
    logic        rw;
    logic        dirty;
    logic        cache_inhibit_flag;
  } tlb_ent_s;
  typedef enum logic [3:0] {
    S_IDLE, S_SEG0, S_SEG1, S_LOOK, S_DIR, S_DIRW, S_TBL, S_TBLW, S_INV
  } walk_e;
endpackage

/* File: src/addr_gen.sv */
`timescale 1ns/10ps
`include "lat_map.svh"
module addr_gen (
  input  wire logic          has_base,
  input  lat_pkg::word_t     base_val,
  input  wire logic          has_index,
  input  wire logic          index_is_sp,
  input  lat_pkg::word_t     index_val,
  input  wire logic [1:0]    scale_sel,
  input  wire logic          has_disp,
  input  lat_pkg::word_t     disp_val,
  input  wire logic [15:0]   seg_val,
  input  lat_pkg::word_t     seg_base,
  input  wire logic          high_mem_en,
  output lat_pkg::word_t     offset,
  output lat_pkg::word_t     linear,
  output lat_pkg::word_t     real_addr,
  output logic               illegal,
  output logic               gp,
  output logic               seg_over
);
  import lat_pkg::*;

  word_t       idx_sc;
  logic [20:0] sum21;

  assign idx_sc    = has_index ? (index_val << scale_sel) : '0;
  assign offset    = (has_base ? base_val : '0) + idx_sc + (has_disp ? disp_val : '0);
  // index alone or nothing at all is not among the legal forms
  assign illegal   = (has_index && index_is_sp) || (!has_base && !has_disp);
  assign sum21     = {1'b0, seg_val, 4'h0} + {5'h00, offset[15:0]};
  assign real_addr = {11'h000, sum21};
  assign gp        = offset > `REAL_OFS_MAX;
  assign seg_over  = sum21[`REAL_CARRY] && !high_mem_en;
  assign linear    = seg_base + offset;
endmodule

/* File: src/linear_address_translation.sv */
`timescale 1ns/10ps
`include "lat_map.svh"
module linear_address_translation #(
  parameter bit WIDE = 1'b1
) (
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic        REQ_VALID,
  input  wire logic        REQ_WRITE,
  input  wire logic [2:0]  REQ_SEG,
  input  wire logic        PROT_MODE,
  input  wire logic        PAGING_ON,
  input  wire logic        HIGH_MEM_EN,
  input  wire logic        HAS_BASE,
  input  lat_pkg::word_t   BASE_VAL,
  input  wire logic        HAS_INDEX,
  input  wire logic        INDEX_IS_SP,
  input  lat_pkg::word_t   INDEX_VAL,
  input  wire logic [1:0]  SCALE_SEL,
  input  wire logic        HAS_DISP,
  input  lat_pkg::word_t   DISP_VAL,
  input  wire logic [1:0]  CUR_PRIV,
  input  wire logic        SEG_LOAD,
  input  wire logic [2:0]  SEG_LOAD_IDX,
  input  wire logic [15:0] SEG_SELECTOR,
  input  lat_pkg::word_t   GLOBAL_DESCRIPTOR_TABLE_BASE,
  input  lat_pkg::word_t   LOCAL_DESCRIPTOR_TABLE_BASE,
  input  wire logic        DIRECTORY_BASE_WR,
  input  lat_pkg::word_t   DIRECTORY_BASE_DATA,
  input  wire logic        SINGLE_ENTRY_INVALIDATE,
  input  lat_pkg::word_t   INVALIDATE_ADDR,
  input  wire logic        MEM_ACK,
  input  lat_pkg::word_t   MEM_RDATA,
  output logic             READY,
  output logic             RSP_VALID,
  output lat_pkg::word_t   PHYS_ADDR,
  output logic             CACHE_INHIBIT_FLAG,
  output logic             FAULT_MODE,
  output logic             FAULT_GP,
  output logic             FAULT_SEG_LIMIT,
  output logic             FAULT_PAGE,
  output logic             MEM_REQ,
  output logic             MEM_WE,
  output lat_pkg::word_t   MEM_ADDR,
  output lat_pkg::word_t   MEM_WDATA,
  output lat_pkg::word_t   DIRECTORY_BASE_REGISTER
);
  import lat_pkg::*;

  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);

  localparam word_t ADDR_MASK = WIDE ? `WIDE_MASK : `NARROW_MASK;

  function automatic logic prot_bad(input logic us, input logic rw, input logic wr,
                                    input logic [1:0] current_privilege_level);
    return (!us && (current_privilege_level > `SUPER_MAX_CPL)) || (wr && !rw);
  endfunction

  walk_e       st_r, st_nxt;
  word_t       lin_r, dte_r, pte_r, cr3_r, desc_lo_r;
  logic        wr_r, hit_old_r;
  logic [1:0]  cpl_r, hit_way_r, victim_r;
  logic [2:0]  seg_idx_r;
  logic [15:0] sel_r;
  logic [31:0] valid_r;
  word_t       seg_base_r [`SEG_COUNT];
  logic [19:0] seg_lim_r  [`SEG_COUNT];
  logic [7:0]  seg_attr_r [`SEG_COUNT];
  logic [15:0] seg_sel_r  [`SEG_COUNT];
  logic        ready_r, rsp_r, nc_r, fmode_r, fgp_r, fseg_r, fpage_r, mreq_r, mwe_r;
  word_t       phys_r, maddr_r, mwdata_r;

  word_t       ag_off, ag_lin, ag_real, ent_src;
  logic        ag_ill, ag_gp, ag_seg;
  logic        idle, take_cr3, take_inv, take_seg, take_req;
  logic [2:0]  rd_set;
  tlb_ent_s    rd_ent [`TLB_WAYS];
  tlb_ent_s    hit_ent, tlb_ent;
  logic [3:0]  hitv;
  logic [1:0]  hit_way, tlb_way;
  logic        hit, tlb_we;
  logic        mem_go, mem_we, rsp, r_nc, r_mode, r_gp, r_seg, r_page;
  word_t       mem_addr, mem_wdata, r_addr;

  addr_gen u_agen (
    .has_base    (HAS_BASE),
    .base_val    (BASE_VAL),
    .has_index   (HAS_INDEX),
    .index_is_sp (INDEX_IS_SP),
    .index_val   (INDEX_VAL),
    .scale_sel   (SCALE_SEL),
    .has_disp    (HAS_DISP),
    .disp_val    (DISP_VAL),
    .seg_val     (seg_sel_r[REQ_SEG]),
    .seg_base    (seg_base_r[REQ_SEG]),
    .high_mem_en (HIGH_MEM_EN),
    .offset      (ag_off),
    .linear      (ag_lin),
    .real_addr   (ag_real),
    .illegal     (ag_ill),
    .gp          (ag_gp),
    .seg_over    (ag_seg)
  );

  // priority: base write, invalidate, selector load, translation
  assign idle     = st_r == S_IDLE;
  assign take_cr3 = idle && DIRECTORY_BASE_WR;
  assign take_inv = idle && !DIRECTORY_BASE_WR && SINGLE_ENTRY_INVALIDATE;
  assign take_seg = idle && !DIRECTORY_BASE_WR && !SINGLE_ENTRY_INVALIDATE && SEG_LOAD;
  assign take_req = idle && !DIRECTORY_BASE_WR && !SINGLE_ENTRY_INVALIDATE && !SEG_LOAD
                    && REQ_VALID;
  assign rd_set   = take_inv ? INVALIDATE_ADDR[`TLB_SET] : ag_lin[`TLB_SET];

  tlb_store u_tlb (
    .clk    (MCLK),
    .rd_set (rd_set),
    .wr_en  (tlb_we),
    .wr_set (lin_r[`TLB_SET]),
    .wr_way (tlb_way),
    .wr_ent (tlb_ent),
    .rd_ent (rd_ent)
  );

  always_comb begin
    hit_ent = rd_ent[0];
    hit_way = 2'h0;
    for (int w = 0; w < `TLB_WAYS; w++) begin
      hitv[w] = valid_r[{lin_r[`TLB_SET], 2'(w)}] && (rd_ent[w].tag == lin_r[`TLB_TAG]);
      if (hitv[w]) begin
        hit_ent = rd_ent[w];
        hit_way = 2'(w);
      end
    end
  end
  assign hit = |hitv;

  // refill the way that already held the page, else round robin
  assign tlb_way       = hit_old_r ? hit_way_r : victim_r;
  assign ent_src       = (st_r == S_DIR) ? MEM_RDATA : dte_r;
  assign tlb_ent.tag   = lin_r[`TLB_TAG];
  assign tlb_ent.frame = MEM_RDATA[`ENT_BASE];
  assign tlb_ent.us    = dte_r[`ENT_US] && MEM_RDATA[`ENT_US];
  assign tlb_ent.rw    = dte_r[`ENT_RW] && MEM_RDATA[`ENT_RW];
  assign tlb_ent.dirty = MEM_RDATA[`ENT_D] || wr_r;
  assign tlb_ent.cache_inhibit_flag   = MEM_RDATA[`ENT_PCD];

  always_comb begin
    st_nxt    = st_r;
    mem_go    = 1'b0;
    mem_we    = 1'b0;
    mem_addr  = maddr_r;
    mem_wdata = mwdata_r;
    rsp       = 1'b0;
    r_addr    = '0;
    r_nc      = 1'b0;
    r_mode    = 1'b0;
    r_gp      = 1'b0;
    r_seg     = 1'b0;
    r_page    = 1'b0;
    tlb_we    = 1'b0;
    unique case (st_r)
      S_IDLE: begin
        if (take_seg && PROT_MODE) begin
          st_nxt   = S_SEG0;
          mem_go   = 1'b1;
          mem_addr = (SEG_SELECTOR[`SEL_TABLE] ? LOCAL_DESCRIPTOR_TABLE_BASE
                      : GLOBAL_DESCRIPTOR_TABLE_BASE)
                     + {16'h0000, SEG_SELECTOR[`SEL_IDX], 3'h0};
        end else if (take_inv) begin
          st_nxt = S_INV;
        end else if (take_req) begin
          if (ag_ill) begin
            rsp    = 1'b1;
            r_mode = 1'b1;
          end else if (!PROT_MODE) begin
            rsp    = 1'b1;
            r_addr = ag_real;
            r_gp   = ag_gp;
            r_seg  = ag_seg;
          end else if (!PAGING_ON) begin
            rsp    = 1'b1;
            r_addr = ag_lin;
          end else begin
            st_nxt = S_LOOK;
          end
        end
      end
      S_SEG0: begin
        if (MEM_ACK) begin
          st_nxt   = S_SEG1;
          mem_go   = 1'b1;
          mem_addr = maddr_r + `DESC_HI;
        end
      end
      S_SEG1: begin
        if (MEM_ACK) begin
          st_nxt = S_IDLE;
        end
      end
      S_LOOK: begin
        st_nxt = S_IDLE;
        if (hit && prot_bad(hit_ent.us, hit_ent.rw, wr_r, cpl_r)) begin
          rsp    = 1'b1;
          r_page = 1'b1;
        end else if (hit && !(wr_r && !hit_ent.dirty)) begin
          rsp    = 1'b1;
          r_addr = {hit_ent.frame, lin_r[`ENT_OFS]};
          r_nc   = hit_ent.cache_inhibit_flag;
        end else begin
          // a clean hit on a write still walks so the dirty bit gets set
          st_nxt   = S_DIR;
          mem_go   = 1'b1;
          mem_addr = {cr3_r[`ENT_BASE], lin_r[`DIR_IDX], 2'h0};
        end
      end
      S_DIR: begin
        if (MEM_ACK) begin
          if (!MEM_RDATA[`ENT_P]) begin
            st_nxt = S_IDLE;
            rsp    = 1'b1;
            r_page = 1'b1;
          end else if (!MEM_RDATA[`ENT_A]) begin
            st_nxt    = S_DIRW;
            mem_go    = 1'b1;
            mem_we    = 1'b1;
            mem_wdata = MEM_RDATA | (`ENT_BIT << `ENT_A);
          end else begin
            st_nxt   = S_TBL;
            mem_go   = 1'b1;
            mem_addr = {ent_src[`ENT_BASE], lin_r[`TBL_IDX], 2'h0};
          end
        end
      end
      S_DIRW: begin
        if (MEM_ACK) begin
          st_nxt   = S_TBL;
          mem_go   = 1'b1;
          mem_addr = {ent_src[`ENT_BASE], lin_r[`TBL_IDX], 2'h0};
        end
      end
      S_TBL: begin
        if (MEM_ACK) begin
          if (!MEM_RDATA[`ENT_P]) begin
            st_nxt = S_IDLE;
            rsp    = 1'b1;
            r_page = 1'b1;
          end else if (prot_bad(tlb_ent.us, tlb_ent.rw, wr_r, cpl_r)) begin
            st_nxt = S_IDLE;
            rsp    = 1'b1;
            r_page = 1'b1;
          end else begin
            tlb_we = 1'b1;
            if (!MEM_RDATA[`ENT_A] || (wr_r && !MEM_RDATA[`ENT_D])) begin
              st_nxt    = S_TBLW;
              mem_go    = 1'b1;
              mem_we    = 1'b1;
              mem_wdata = MEM_RDATA | (`ENT_BIT << `ENT_A)
                          | ((wr_r ? `ENT_BIT : '0) << `ENT_D);
            end else begin
              st_nxt = S_IDLE;
              rsp    = 1'b1;
              r_addr = {MEM_RDATA[`ENT_BASE], lin_r[`ENT_OFS]};
              r_nc   = MEM_RDATA[`ENT_PCD];
            end
          end
        end
      end
      S_TBLW: begin
        if (MEM_ACK) begin
          st_nxt = S_IDLE;
          rsp    = 1'b1;
          r_addr = {pte_r[`ENT_BASE], lin_r[`ENT_OFS]};
          r_nc   = pte_r[`ENT_PCD];
        end
      end
      S_INV: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      st_r    <= S_IDLE;
      ready_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      ready_r <= st_nxt == S_IDLE;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      lin_r     <= '0;
      wr_r      <= 1'b0;
      cpl_r     <= 2'h0;
      dte_r     <= '0;
      pte_r     <= '0;
      hit_old_r <= 1'b0;
      hit_way_r <= 2'h0;
    end else begin
      if (take_req) begin
        lin_r <= ag_lin;
        wr_r  <= REQ_WRITE;
        cpl_r <= CUR_PRIV;
      end else if (take_inv) begin
        lin_r <= INVALIDATE_ADDR;
      end
      if (st_r == S_LOOK) begin
        hit_old_r <= hit;
        hit_way_r <= hit_way;
      end
      if (st_r == S_DIR && MEM_ACK) begin
        dte_r <= MEM_RDATA;
      end
      if (st_r == S_TBL && MEM_ACK) begin
        pte_r <= MEM_RDATA;
      end
    end
  end

  // bus holds the request until acknowledged
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      mreq_r   <= 1'b0;
      mwe_r    <= 1'b0;
      maddr_r  <= '0;
      mwdata_r <= '0;
    end else if (mem_go) begin
      mreq_r   <= 1'b1;
      mwe_r    <= mem_we;
      maddr_r  <= mem_addr & ADDR_MASK;
      mwdata_r <= mem_wdata;
    end else if (MEM_ACK) begin
      mreq_r <= 1'b0;
      mwe_r  <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rsp_r   <= 1'b0;
      phys_r  <= '0;
      nc_r    <= 1'b0;
      fmode_r <= 1'b0;
      fgp_r   <= 1'b0;
      fseg_r  <= 1'b0;
      fpage_r <= 1'b0;
    end else begin
      rsp_r <= rsp;
      if (rsp) begin
        phys_r  <= r_addr & ADDR_MASK; // low byte address of operand
        nc_r    <= r_nc;
        fmode_r <= r_mode;
        fgp_r   <= r_gp;
        fseg_r  <= r_seg;
        fpage_r <= r_page;
      end
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      cr3_r <= '0;
    end else if (take_cr3) begin
      cr3_r <= DIRECTORY_BASE_DATA;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      valid_r  <= '0;
      victim_r <= 2'h0;
    end else begin
      if (take_cr3) begin
        valid_r <= '0;
      end else if (st_r == S_INV) begin
        for (int w = 0; w < `TLB_WAYS; w++) begin
          if (hitv[w]) begin
            valid_r[{lin_r[`TLB_SET], 2'(w)}] <= 1'b0;
          end
        end
      end else if (tlb_we) begin
        valid_r[{lin_r[`TLB_SET], tlb_way}] <= 1'b1;
      end
      if (tlb_we && !hit_old_r) begin
        victim_r <= victim_r + 2'h1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      seg_idx_r <= 3'h0;
      sel_r     <= 16'h0000;
      desc_lo_r <= '0;
      for (int s = 0; s < `SEG_COUNT; s++) begin
        seg_base_r[s] <= '0;
        seg_lim_r[s]  <= 20'h0_0000;
        seg_attr_r[s] <= 8'h00;
        seg_sel_r[s]  <= 16'h0000;
      end
    end else begin
      if (take_seg) begin
        seg_idx_r <= SEG_LOAD_IDX;
        sel_r     <= SEG_SELECTOR;
        if (!PROT_MODE) begin
          seg_sel_r[SEG_LOAD_IDX]  <= SEG_SELECTOR;
          seg_base_r[SEG_LOAD_IDX] <= {12'h000, SEG_SELECTOR, 4'h0};
        end
      end
      if (st_r == S_SEG0 && MEM_ACK) begin
        desc_lo_r <= MEM_RDATA;
      end
      if (st_r == S_SEG1 && MEM_ACK) begin
        seg_sel_r[seg_idx_r]  <= sel_r;
        seg_base_r[seg_idx_r] <= {MEM_RDATA[`DHI_BASE_TOP], MEM_RDATA[`DHI_BASE_MID],
                                  desc_lo_r[`DLO_BASE]};
        seg_lim_r[seg_idx_r]  <= {MEM_RDATA[`DHI_LIM], desc_lo_r[`DLO_LIM]};
        seg_attr_r[seg_idx_r] <= MEM_RDATA[`DHI_ATTR];
      end
    end
  end

  assign READY                   = ready_r;
  assign RSP_VALID               = rsp_r;
  assign PHYS_ADDR               = phys_r;
  assign CACHE_INHIBIT_FLAG      = nc_r;
  assign FAULT_MODE              = fmode_r;
  assign FAULT_GP                = fgp_r;
  assign FAULT_SEG_LIMIT         = fseg_r;
  assign FAULT_PAGE              = fpage_r;
  assign MEM_REQ                 = mreq_r;
  assign MEM_WE                  = mwe_r;
  assign MEM_ADDR                = maddr_r;
  assign MEM_WDATA               = mwdata_r;
  assign DIRECTORY_BASE_REGISTER = cr3_r;

  narrow_space_a: assert property (RSP_VALID && !WIDE |-> PHYS_ADDR[31:24] == 8'h00)
    else $error("narrow variant address exceeds 24 bits");
  sp_index_a: assert property (take_req && HAS_INDEX && INDEX_IS_SP
                               |=> RSP_VALID && FAULT_MODE)
    else $error("stack pointer index not refused");
  real_addr_a: assert property (take_req && !ag_ill && !PROT_MODE
                                |=> RSP_VALID && PHYS_ADDR == ($past(ag_real) & ADDR_MASK))
    else $error("real mode address wrong");
  real_gp_a: assert property (take_req && !ag_ill && !PROT_MODE
                              && ag_off > `REAL_OFS_MAX |=> FAULT_GP)
    else $error("real mode offset overflow not faulted");
  flat_linear_a: assert property (take_req && !ag_ill && PROT_MODE && !PAGING_ON
                                  |=> RSP_VALID && PHYS_ADDR == ($past(ag_lin) & ADDR_MASK))
    else $error("unpaged linear address wrong");
  dir_fetch_a: assert property (st_r == S_LOOK && !hit
                                |=> MEM_REQ && MEM_ADDR
                                    == ({cr3_r[`ENT_BASE], lin_r[`DIR_IDX], 2'h0} & ADDR_MASK))
    else $error("directory entry address wrong");
  absent_fault_a: assert property (st_r == S_TBL && MEM_ACK && !MEM_RDATA[`ENT_P]
                                   |=> RSP_VALID && FAULT_PAGE && !MEM_REQ)
    else $error("absent page not faulted");
  hit_skip_a: assert property (st_r == S_LOOK && hit && !wr_r
                               |=> RSP_VALID && !MEM_REQ && READY)
    else $error("buffer hit still walked");
  flush_all_a: assert property (take_cr3 |=> valid_r == 32'h0000_0000)
    else $error("base write did not flush buffer");
endmodule

/* File: src/tlb_store.sv */
`timescale 1ns/10ps
`include "lat_map.svh"
module tlb_store (
  input  wire logic        clk,
  input  wire logic [2:0]  rd_set,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_set,
  input  wire logic [1:0]  wr_way,
  input  lat_pkg::tlb_ent_s wr_ent,
  output lat_pkg::tlb_ent_s rd_ent [`TLB_WAYS]
);
  import lat_pkg::*;

  // no reset: valid bits live in the controller so a flush is one cycle
  for (genvar w = 0; w < `TLB_WAYS; w++) begin : g_way
    tlb_ent_s mem [`TLB_SETS];
    always_ff @(posedge clk) begin
      if (wr_en && wr_way == 2'(w)) begin
        mem[wr_set] <= wr_ent;
      end
      rd_ent[w] <= mem[rd_set];
    end
  end
endmodule

/* File: tb/linear_address_translation_tb_top.sv */
`timescale 1ns/10ps
module linear_address_translation_tb_top;
  import lat_pkg::*;
  logic MCLK, NRST, REQ_VALID, REQ_WRITE, PROT_MODE, PAGING_ON, HIGH_MEM_EN, HAS_BASE, slow;
  logic HAS_INDEX, INDEX_IS_SP, HAS_DISP, SEG_LOAD, DIRECTORY_BASE_WR, SINGLE_ENTRY_INVALIDATE;
  logic MEM_ACK, READY, RSP_VALID, CACHE_INHIBIT_FLAG, FAULT_MODE, FAULT_GP, FAULT_SEG_LIMIT;
  logic FAULT_PAGE, MEM_REQ, MEM_WE;
  logic [2:0]  REQ_SEG, SEG_LOAD_IDX;
  logic [1:0]  SCALE_SEL, CUR_PRIV;
  logic [15:0] SEG_SELECTOR;
  word_t BASE_VAL, INDEX_VAL, DISP_VAL, GLOBAL_DESCRIPTOR_TABLE_BASE, INVALIDATE_ADDR;
  word_t LOCAL_DESCRIPTOR_TABLE_BASE, DIRECTORY_BASE_DATA, MEM_RDATA, PHYS_ADDR, MEM_ADDR;
  word_t MEM_WDATA, DIRECTORY_BASE_REGISTER;
  int    fail_count, cmp_count, cyc, acks;
  linear_address_translation linear_address_translation_inst (.MCLK, .NRST, .REQ_VALID,
    .REQ_WRITE, .REQ_SEG, .PROT_MODE, .PAGING_ON, .HIGH_MEM_EN, .HAS_BASE, .BASE_VAL,
    .HAS_INDEX, .INDEX_IS_SP, .INDEX_VAL, .SCALE_SEL, .HAS_DISP, .DISP_VAL, .CUR_PRIV,
    .SEG_LOAD, .SEG_LOAD_IDX, .SEG_SELECTOR, .GLOBAL_DESCRIPTOR_TABLE_BASE,
    .LOCAL_DESCRIPTOR_TABLE_BASE, .DIRECTORY_BASE_WR, .DIRECTORY_BASE_DATA,
    .SINGLE_ENTRY_INVALIDATE, .INVALIDATE_ADDR, .MEM_ACK, .MEM_RDATA, .READY, .RSP_VALID,
    .PHYS_ADDR, .CACHE_INHIBIT_FLAG, .FAULT_MODE, .FAULT_GP, .FAULT_SEG_LIMIT, .FAULT_PAGE,
    .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_WDATA, .DIRECTORY_BASE_REGISTER);
  mem_model mem_model_inst (.clk(MCLK), .rst_n(NRST), .slow(slow), .mem_req(MEM_REQ),
    .mem_we(MEM_WE), .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA), .mem_ack(MEM_ACK),
    .mem_rdata(MEM_RDATA));
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  // whole run needs about 200 cycles
  always @(posedge MCLK) begin
    cyc++;
    if (MEM_REQ === 1'b1 && MEM_ACK === 1'b1) acks++;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(input word_t got, input word_t exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic pm(input word_t a, input word_t d);
    mem_model_inst.mem[a] = d;
  endtask
  task automatic ea(input logic hb, input word_t b, input logic hx, input word_t x,
                    input logic [1:0] sc, input logic hd, input word_t d);
    {HAS_BASE, BASE_VAL, HAS_INDEX, INDEX_VAL} = {hb, b, hx, x};
    {SCALE_SEL, HAS_DISP, DISP_VAL} = {sc, hd, d};
  endtask
  task automatic go(input logic wr);
    int n;
    n = 0;
    // one edge between requests so the strobe never drops and rises in one step
    tick(1);
    while (READY !== 1'b1) tick(1);
    REQ_WRITE = wr;
    REQ_VALID = 1'b1;
    tick(1);
    REQ_VALID = 1'b0;
    while (RSP_VALID !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    chk(RSP_VALID, 1);
  endtask
  // k: 0 selector load (slot in v[18:16]), 1 directory base write, else invalidate
  task automatic cmd(input int k, input word_t v);
    while (READY !== 1'b1) tick(1);
    case (k)
      0: {SEG_LOAD, SEG_LOAD_IDX, SEG_SELECTOR} = {1'b1, v[18:16], v[15:0]};
      1: {DIRECTORY_BASE_WR, DIRECTORY_BASE_DATA} = {1'b1, v};
      default: {SINGLE_ENTRY_INVALIDATE, INVALIDATE_ADDR} = {1'b1, v};
    endcase
    tick(1);
    {SEG_LOAD, DIRECTORY_BASE_WR, SINGLE_ENTRY_INVALIDATE} = 3'h0;
    tick(2);
    while (READY !== 1'b1) tick(1);
  endtask
  task automatic t_real();
    cmd(0, 32'h0000_1234);
    cmd(0, 32'h0003_FFFF);
    ea(1, 32'h0000_0010, 0, 0, 0, 1, 32'h0000_0005);
    go(0);
    chk(PHYS_ADDR, 32'h0001_2355);
    chk(FAULT_GP, 0);
    REQ_SEG = 3'h3;
    DISP_VAL = 32'h0000_0010;
    go(0);
    chk(FAULT_SEG_LIMIT, 1);
    HIGH_MEM_EN = 1'b1;
    go(0);
    chk(PHYS_ADDR, 32'h0010_0010);
    REQ_SEG = 3'h0;
    DISP_VAL = 32'h0001_0000;
    go(0);
    chk(FAULT_GP, 1);
    $display("test real mode done");
  endtask
  task automatic t_prot();
    pm(32'h0000_8008, 32'h3344_FFFF);
    pm(32'h0000_800C, 32'h1100_0022);
    PROT_MODE = 1'b1;
    acks = 0;
    cmd(0, 32'h0001_0008);
    chk(acks, 2);
    cmd(0, 32'h0002_0010);
    REQ_SEG = 3'h1;
    for (int s = 0; s < 4; s++) begin
      ea(1, 32'h0000_0100, 1, 32'h0000_0010, s[1:0], 1, 32'h0000_0004);
      go(0);
      chk(PHYS_ADDR, 32'h1122_3448 + (32'h0000_0010 << s));
    end
    ea(0, 0, 0, 0, 0, 1, 32'h0000_0040);
    go(0);
    chk(PHYS_ADDR, 32'h1122_3384);
    LOCAL_DESCRIPTOR_TABLE_BASE = 32'h0000_9000;
    pm(32'h0000_9008, 32'h5566_0000);
    pm(32'h0000_900C, 32'h7700_0088);
    cmd(0, 32'h0004_000C);
    REQ_SEG = 3'h4;
    go(0);
    chk(PHYS_ADDR, 32'h7788_55A6);
    {HAS_INDEX, INDEX_IS_SP} = 2'b11;
    go(0);
    chk(FAULT_MODE, 1);
    INDEX_IS_SP = 1'b0;
    ea(0, 0, 1, 32'h0000_0010, 0, 0, 0);
    go(0);
    chk(FAULT_MODE, 1);
    $display("test protected mode done");
  endtask
  task automatic t_page();
    pm(32'h0001_0004, 32'h0002_0007);
    pm(32'h0002_0014, 32'h0003_0017);
    pm(32'h0002_0018, 32'h0003_1003);
    pm(32'h0002_001C, 32'h0003_2005);
    cmd(1, 32'h0001_0000);
    chk(DIRECTORY_BASE_REGISTER, 32'h0001_0000);
    {PAGING_ON, REQ_SEG, CUR_PRIV, slow} = {1'b1, 3'h2, 2'h3, 1'b1};
    ea(0, 0, 0, 0, 0, 1, 32'h0040_5123);
    go(0);
    chk(PHYS_ADDR, 32'h0003_0123);
    chk(CACHE_INHIBIT_FLAG, 1);
    chk(mem_model_inst.mem[32'h0001_0004], 32'h0002_0027);
    chk(mem_model_inst.mem[32'h0002_0014], 32'h0003_0037);
    acks = 0;
    go(0);
    chk(acks, 0);
    go(1);
    chk(mem_model_inst.mem[32'h0002_0014], 32'h0003_0077);
    DISP_VAL = 32'h0040_6000;
    go(0);
    chk(FAULT_PAGE, 1);
    CUR_PRIV = 2'h2;
    go(0);
    chk(PHYS_ADDR, 32'h0003_1000);
    DISP_VAL = 32'h0040_7000;
    go(1);
    chk(FAULT_PAGE, 1);
    DISP_VAL = 32'h0040_8000;
    go(0);
    chk(FAULT_PAGE, 1);
    DISP_VAL = 32'h0080_0000;
    go(0);
    chk(FAULT_PAGE, 1);
    pm(32'h0002_0014, 32'h0004_0077);
    pm(32'h0002_0018, 32'h0006_1007);
    cmd(2, 32'h0040_5000);
    DISP_VAL = 32'h0040_5123;
    go(0);
    chk(PHYS_ADDR, 32'h0004_0123);
    DISP_VAL = 32'h0040_6000;
    go(0);
    chk(PHYS_ADDR, 32'h0003_1000);
    cmd(1, 32'h0001_0000);
    go(0);
    chk(PHYS_ADDR, 32'h0006_1000);
    $display("test paging done");
  endtask
  initial begin
    {NRST, REQ_VALID, REQ_WRITE, PROT_MODE, PAGING_ON, HIGH_MEM_EN, HAS_BASE, slow} = '0;
    {HAS_INDEX, INDEX_IS_SP, HAS_DISP, SEG_LOAD, DIRECTORY_BASE_WR, SINGLE_ENTRY_INVALIDATE} = '0;
    {REQ_SEG, SEG_LOAD_IDX, SCALE_SEL, CUR_PRIV, SEG_SELECTOR, BASE_VAL, INDEX_VAL} = '0;
    {DISP_VAL, DIRECTORY_BASE_DATA, INVALIDATE_ADDR, LOCAL_DESCRIPTOR_TABLE_BASE} = '0;
    GLOBAL_DESCRIPTOR_TABLE_BASE = 32'h0000_8000;
    {fail_count, cmp_count, cyc, acks} = '0;
    tick(12);
    chk(READY, 0);
    NRST = 1'b1;
    tick(1);
    chk(READY, 1);
    $display("test reset done");
    t_real();
    t_prot();
    t_page();
    give_verdict();
  end
endmodule

/* File: tb/mem_model.sv */
`timescale 1ns/10ps
module mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0]  wait_r;
  // ack one cycle, data only then; otherwise data toggles so stale reads show
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      wait_r <= 2'h0;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_req && !mem_ack && wait_r == (slow ? 2'h2 : 2'h0)) begin
      mem_ack <= 1'b1;
      wait_r <= 2'h0;
      if (mem_we) mem[mem_addr] = mem_wdata;
      else mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0000_0000;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) wait_r <= wait_r + 2'h1;
    end
  end
endmodule
